// File: urpsc_consts.vh
// Constants for the root port status and control block
`ifndef URPSC_CONSTS_VH
`define URPSC_CONSTS_VH

// Register map
`define URPSC_ADDR_W        8
`define URPSC_ROOT_PORT_OFS 8'h64
`define URPSC_DATA_W        32

// Field positions
`define URPSC_PTC_HI        19
`define URPSC_PTC_LO        16
`define URPSC_PIC_HI        15
`define URPSC_PIC_LO        14
`define URPSC_PO_BIT        13
`define URPSC_PP_BIT        12
`define URPSC_LS_HI         11
`define URPSC_LS_LO         10
`define URPSC_PR_BIT        8
`define URPSC_PORT_SUSPEND_BIT      7
`define URPSC_FPR_BIT       6
`define URPSC_PED_BIT       2
`define URPSC_CSC_BIT       1
`define URPSC_CCS_BIT       0

// Reset value and write masks
`define URPSC_RESET_VAL     32'h00002000
`define URPSC_WR_MASK       32'hffff3efc
`define URPSC_PP_MASK       32'h00001000
`define URPSC_ZERO32        32'h00000000
`define URPSC_PTC_IDLE      4'h0
`define URPSC_PIC_RESET     2'h0

// Power settle time
`define URPSC_SETTLE_MS     20
`define URPSC_CLK_MHZ       200
`define URPSC_SETTLE_W      22
`define URPSC_SETTLE_CYC    22'h3d0900
`define URPSC_CNT_ZERO      22'h000000
`define URPSC_CNT_ONE       22'h000001

`endif

// File: urpsc_peer.sv
// Behavioural peripheral on the downstream port
`default_nettype none
module urpsc_peer (
  input  wire logic clk_in,
  input  wire logic plug_in,
  input  wire logic wake_in,
  output var logic  connect_out,
  output var logic  jk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    connect_out = 1'b0;
    jk_out = 1'b0;
  end
  // Attach and J-K signalling one cycle after command
  always @(posedge clk_in) begin
    connect_out <= plug_in;
    jk_out <= wake_in;
  end
endmodule
`default_nettype wire

// File: urpsc_root_port.v
// Root port status and control register with connect, resume and power tracking
`default_nettype none
`include "urpsc_consts.vh"

// Functional notes
// - Register lives in the aux well; cleared only by power-up or controller reset.
// - After reset the port shows nothing attached and port disabled.
// - With power control present, state writes other than connect change clear ignored until port power set.
// - Fixed bit layout of test, indicator, owner, power, line, reset, suspend, etc.
// - Reset value has ownership bit one, all else zero.
// - Indicator, port reset and connect status read-only; connect change write-one-to-clear; all others read-write.
// - Test control zero means normal; nonzero selects that test mode.
// - Global change flag set on owned-port change or resume on suspended port.
module urpsc_root_port #(
  parameter [`URPSC_SETTLE_W-1:0] SETTLE_CYC = `URPSC_SETTLE_CYC
) (
  // Clock, reset and enable
  input  wire                      clk_in,
  input  wire                      reset_n_in,
  input  wire                      ce_in,

  // Register bus
  input  wire [`URPSC_ADDR_W-1:0]  addr_in,
  input  wire [`URPSC_DATA_W-1:0]  wdata_in,
  input  wire                      wr_in,
  input  wire                      rd_in,

  // Straps and port hardware state
  input  wire                      power_ctl_present_in,
  input  wire                      connect_in,
  input  wire                      port_reset_in,
  input  wire [1:0]                indicator_in,
  input  wire                      resume_detect_in,
  input  wire                      port_change_clear_in,

  // Read data
  output reg  [`URPSC_DATA_W-1:0]  rdata_out,

  // Port control fields
  output wire                      port_power_out,
  output wire                      port_power_stable_out,
  output wire                      port_enabled_out,
  output wire                      port_suspend_out,
  output wire                      force_port_resume_out,
  output wire                      port_ownership_out,
  output wire [1:0]                line_state_out,
  output wire [3:0]                port_test_control_out,
  output wire                      test_mode_active_out,

  // Status flags
  output wire                      connect_change_out,
  output wire                      current_connect_status_out,
  output wire                      global_port_change_flag_out
);

  // Address decode shared by read and write
  function addr_hit;
    input [`URPSC_ADDR_W-1:0] a;
    begin
      addr_hit = (a == `URPSC_ROOT_PORT_OFS);
    end
  endfunction

  // Software-writable bits, reserved bits included
  reg  [`URPSC_DATA_W-1:0]  ctl_q;
  reg  [`URPSC_DATA_W-1:0]  ctl_d;

  // Connect state
  reg                       ccs_q;
  reg                       csc_q;
  reg                       csc_d;

  // Mirrored hardware state
  reg                       pr_q;
  reg  [1:0]                pic_q;

  // Global change flag
  reg                       gpc_q;
  reg                       gpc_d;

  // Test mode flag
  reg                       test_act_q;
  wire                      test_next;

  // Power settle timer
  reg  [`URPSC_SETTLE_W-1:0] settle_cnt_q;
  reg                       stable_q;
  wire                      settle_done;

  // Bus decode and write masking
  wire                      wr_hit;
  wire                      rd_hit;
  wire                      pwr_locked;
  wire [`URPSC_DATA_W-1:0]  wmask;
  wire [`URPSC_DATA_W-1:0]  wr_merge;

  // Hardware event terms
  wire                      connect_toggle;
  wire                      resume_evt;
  wire                      csc_w1c;
  wire                      gpc_set;

  // Read view and write stage
  reg  [`URPSC_DATA_W-1:0]  rd_val;
  reg  [`URPSC_DATA_W-1:0]  ctl_wr;

  // Bus strobes qualified by the decode
  assign wr_hit = wr_in & addr_hit(addr_in);
  assign rd_hit = rd_in & addr_hit(addr_in);

  // With power control present, only the power bit and the connect change write-one-to-clear take effect until power is on
  assign pwr_locked = power_ctl_present_in & ~ctl_q[`URPSC_PP_BIT];

  // Read-only and locked bits keep their stored value
  assign wmask    = pwr_locked ? `URPSC_PP_MASK : `URPSC_WR_MASK;
  assign wr_merge = (ctl_q & ~wmask) | (wdata_in & wmask);

  // Connect status flips when the line differs from the stored view
  assign connect_toggle = connect_in ^ ccs_q;

  // Resume only counts while the port is suspended
  assign resume_evt = resume_detect_in & ctl_q[`URPSC_PORT_SUSPEND_BIT];

  // Writing one to the change bit clears it
  assign csc_w1c = wr_hit & wdata_in[`URPSC_CSC_BIT];

  // Change on a port kept here, or a resume, raises the global flag
  assign gpc_set = (connect_toggle & ~ctl_q[`URPSC_PO_BIT]) | resume_evt;

  // Read view: stored bits with read-only fields laid over them
  always @* begin
    rd_val = ctl_q;
    rd_val[`URPSC_PIC_HI:`URPSC_PIC_LO] = pic_q;
    rd_val[`URPSC_PR_BIT]               = pr_q;
    rd_val[`URPSC_CSC_BIT]              = csc_q;
    rd_val[`URPSC_CCS_BIT]              = ccs_q;
  end

  // Stored bits after a software write
  always @* begin
    ctl_wr = ctl_q;
    if (wr_hit) begin
      ctl_wr = wr_merge;
    end
  end

  // Resume detect forces the resume bit on top of any write
  always @* begin
    ctl_d = ctl_wr;
    if (resume_evt) begin
      ctl_d[`URPSC_FPR_BIT] = 1'b1;
    end
  end

  // Test mode follows the next test control value
  assign test_next = (ctl_d[`URPSC_PTC_HI:`URPSC_PTC_LO] != `URPSC_PTC_IDLE);

  // Next value of connect change, set wins over clear
  always @* begin
    csc_d = csc_q;
    if (csc_w1c) begin
      csc_d = 1'b0;
    end
    if (connect_toggle) begin
      csc_d = 1'b1;
    end
  end

  // Next value of global change flag, set wins over clear
  always @* begin
    gpc_d = gpc_q;
    if (port_change_clear_in) begin
      gpc_d = 1'b0;
    end
    if (gpc_set) begin
      gpc_d = 1'b1;
    end
  end

  // Writable register bits
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_q <= `URPSC_RESET_VAL;
    end else if (ce_in) begin
      ctl_q <= ctl_d;
    end
  end

  // Current connect status follows the line
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ccs_q <= 1'b0;
    end else if (ce_in) begin
      ccs_q <= connect_in;
    end
  end

  // Connect change flag
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      csc_q <= 1'b0;
    end else if (ce_in) begin
      csc_q <= csc_d;
    end
  end

  // Port reset mirrors hardware state
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pr_q <= 1'b0;
    end else if (ce_in) begin
      pr_q <= port_reset_in;
    end
  end

  // Indicator mirrors hardware state
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pic_q <= `URPSC_PIC_RESET;
    end else if (ce_in) begin
      pic_q <= indicator_in;
    end
  end

  // Global port change flag
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gpc_q <= 1'b0;
    end else if (ce_in) begin
      gpc_q <= gpc_d;
    end
  end

  // Test mode indication from the next test control value
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      test_act_q <= 1'b0;
    end else if (ce_in) begin
      test_act_q <= test_next;
    end
  end

  // Settle count reached
  assign settle_done = (settle_cnt_q >= SETTLE_CYC);

  // Power settle counter restarts whenever power is off
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      settle_cnt_q <= `URPSC_CNT_ZERO;
    end else if (ce_in) begin
      if (!ctl_q[`URPSC_PP_BIT]) begin
        settle_cnt_q <= `URPSC_CNT_ZERO;
      end else if (!settle_done) begin
        settle_cnt_q <= settle_cnt_q + `URPSC_CNT_ONE;
      end
    end
  end

  // Power stable once the count has run out
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stable_q <= 1'b0;
    end else if (ce_in) begin
      if (!ctl_q[`URPSC_PP_BIT]) begin
        stable_q <= 1'b0;
      end else if (settle_done) begin
        stable_q <= 1'b1;
      end
    end
  end

  // Read data stands for one cycle after the strobe
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= `URPSC_ZERO32;
    end else if (ce_in) begin
      if (rd_hit) begin
        rdata_out <= rd_val;
      end else begin
        rdata_out <= `URPSC_ZERO32;
      end
    end
  end

  // Power outputs straight from flops
  assign port_power_out              = ctl_q[`URPSC_PP_BIT];
  assign port_power_stable_out       = stable_q;

  // Port state outputs
  assign port_enabled_out            = ctl_q[`URPSC_PED_BIT];
  assign port_suspend_out            = ctl_q[`URPSC_PORT_SUSPEND_BIT];
  assign force_port_resume_out       = ctl_q[`URPSC_FPR_BIT];

  // Ownership and line state outputs
  assign port_ownership_out          = ctl_q[`URPSC_PO_BIT];
  assign line_state_out              = ctl_q[`URPSC_LS_HI:`URPSC_LS_LO];

  // Test outputs
  assign port_test_control_out       = ctl_q[`URPSC_PTC_HI:`URPSC_PTC_LO];
  assign test_mode_active_out        = test_act_q;

  // Connect status outputs
  assign connect_change_out          = csc_q;
  assign current_connect_status_out  = ccs_q;
  assign global_port_change_flag_out = gpc_q;

endmodule

`default_nettype wire

// File: urpsc_root_port_properties.sv
// Checker for the root port status and control register
`default_nettype none
module urpsc_props #(
  parameter logic [21:0] SETTLE_CYC = 22'h000008
) (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        ce_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic        power_ctl_present_in,
  input wire logic        connect_in,
  input wire logic        resume_detect_in,
  input wire logic [31:0] rdata_out,
  input wire logic        port_power_out,
  input wire logic        port_enabled_out,
  input wire logic        port_suspend_out,
  input wire logic        force_port_resume_out,
  input wire logic        port_ownership_out,
  input wire logic [1:0]  line_state_out,
  input wire logic [3:0]  port_test_control_out,
  input wire logic        test_mode_active_out,
  input wire logic        connect_change_out,
  input wire logic        current_connect_status_out,
  input wire logic        global_port_change_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire hit = ce_in && addr_in == 8'h64;
  wire tog = ce_in && connect_in != current_connect_status_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Port behaviour against register writes and line events
  ccs_follow_a: assert property (ce_in |=> current_connect_status_out == $past(connect_in)) else $error("ccs lag");
  csc_set_a: assert property (tog |=> connect_change_out) else $error("no connect change");
  gpc_set_a: assert property (tog && !port_ownership_out |=> global_port_change_flag_out) else $error("no flag");
  resume_flag_a: assert property (ce_in && resume_detect_in && port_suspend_out
    |=> force_port_resume_out && global_port_change_flag_out) else $error("no resume");
  pwr_lock_a: assert property (hit && wr_in && power_ctl_present_in && !port_power_out |=> $stable({port_enabled_out,
    port_test_control_out, line_state_out, port_ownership_out})) else $error("locked write took");
  wr_field_a: assert property (hit && wr_in && (!power_ctl_present_in || port_power_out) |=> port_test_control_out
    == $past(wdata_in[19:16]) && line_state_out == $past(wdata_in[11:10])) else $error("field lost");
  test_mode_a: assert property (test_mode_active_out == (port_test_control_out != 4'h0)) else $error("mode");
  rd_idle_a: assert property (ce_in && !(hit && rd_in) |=> rdata_out == 32'h0) else $error("rdata");
  cover property (hit && wr_in && power_ctl_present_in && !port_power_out);
  cover property (resume_detect_in && port_suspend_out);
  cover property (connect_change_out && global_port_change_flag_out);
endmodule
bind urpsc_root_port urpsc_props #(.SETTLE_CYC(SETTLE_CYC)) props_u (.clk_in, .reset_n_in, .ce_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .power_ctl_present_in, .connect_in, .resume_detect_in, .rdata_out, .port_power_out,
  .port_enabled_out, .port_suspend_out, .force_port_resume_out, .port_ownership_out, .line_state_out,
  .port_test_control_out, .test_mode_active_out, .connect_change_out, .current_connect_status_out,
  .global_port_change_flag_out);
`default_nettype wire

// File: urpsc_root_port_tb.sv
// Self-checking bench for the root port status and control register
`default_nettype none
module usb_root_port_status_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, prst = 0, clr = 0, plug = 0, wake = 0, pctl = 1;
  logic [1:0] ind = 0;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic conn, jk, pwr_ok, en, tmode, gflag;
  int failures = 0, checks = 0;
  always #2.5 clk_in = ~clk_in;
  urpsc_peer peer_u (.clk_in(clk_in), .plug_in(plug), .wake_in(wake), .connect_out(conn), .jk_out(jk));
  urpsc_root_port #(.SETTLE_CYC(22'h000008)) dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .power_ctl_present_in(pctl),
    .connect_in(conn), .port_reset_in(prst), .indicator_in(ind), .resume_detect_in(jk),
    .port_change_clear_in(clr), .rdata_out(rdata), .port_power_out(), .port_power_stable_out(pwr_ok),
    .port_enabled_out(en), .port_suspend_out(), .force_port_resume_out(), .port_ownership_out(),
    .line_state_out(), .port_test_control_out(), .test_mode_active_out(tmode), .connect_change_out(),
    .current_connect_status_out(), .global_port_change_flag_out(gflag));
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string nm);
    @(posedge clk_in);
    addr <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(nm, exp, rdata);
  endtask
  // Locked writes, power-up, field access and test mode
  task automatic t_power();
    rd(8'h64, 32'h00002000, "reset value");
    chk("enabled", 32'h0, {31'h0, en});
    wr(8'h64, 32'h000f0c84);
    rd(8'h64, 32'h00002000, "locked");
    wr(8'h64, 32'h00001000);
    for (int i = 0; i < 20 && pwr_ok !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    chk("power stable", 32'h1, {31'h0, pwr_ok});
    if (pwr_ok !== 1'b1) close_out();
    wr(8'h64, 32'h000f3cc4);
    rd(8'h64, 32'h000f3cc4, "writable");
    chk("test mode", 32'h1, {31'h0, tmode});
    wr(8'h64, 32'h00001000);
    rd(8'h64, 32'h00001000, "normal");
  endtask
  // Attach, change clear, resume on suspended port, unmapped read
  task automatic t_events();
    @(posedge clk_in);
    prst <= 1'b1;
    ind <= 2'h3;
    plug <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(8'h64, 32'h0000d103, "attach");
    chk("flag", 32'h1, {31'h0, gflag});
    wr(8'h64, 32'h00001002);
    rd(8'h64, 32'h0000d101, "change clear");
    @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    wr(8'h64, 32'h00001080);
    chk("flag clear", 32'h0, {31'h0, gflag});
    wake <= 1'b1;
    @(posedge clk_in);
    wake <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd(8'h64, 32'h0000d1c1, "resume");
    chk("resume flag", 32'h1, {31'h0, gflag});
    rd(8'h60, 32'h0, "unmapped");
  endtask
  // Mid-run controller reset, then writes with no power control present
  task automatic t_reset();
    @(posedge clk_in);
    plug <= 1'b0;
    prst <= 1'b0;
    ind <= 2'h0;
    pctl <= 1'b0;
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(8'h64, 32'h00002000, "reset again");
    wr(8'h64, 32'h000f0c84);
    rd(8'h64, 32'h000f0c84, "no power ctl");
    chk("test mode on", 32'h1, {31'h0, tmode});
    chk("enabled on", 32'h1, {31'h0, en});
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_power();
    t_events();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
